//--- pmu_serial_pkg.sv
// Constants shared by the two-wire register slave.
// Assumes a single system clock much faster than the serial clock.
//
// How it works
// R1: Each data bit is sampled on the serial clock rising edge, one per pulse.
// R2: Data changing while clock is high mid-transfer abandons the transfer.
// R3: Master changes data only while the serial clock is low.
// R4: Bytes are eight bits, most significant first, then an acknowledge slot.
// R5: Data falling with clock high is start; data rising with clock high is stop.
// R6: Only the master makes start and stop; bus busy until after stop.
// R7: Repeated start mid-transfer restarts address decoding.
// R8: Master gives a ninth clock pulse after every byte for acknowledge.
// R9: Sender releases data line during the acknowledge pulse.
// R10: Accepting receiver holds data low through the acknowledge pulse high phase.
// R11: Master leaves data high in the last read byte's acknowledge slot.
// R12: Slave answers only to seven-bit address 7E hex.
// R13: First seven bits are address, eighth is direction: one read, zero write.
// R14: Address acknowledged only on match, otherwise data line stays released.
// R15: First write byte is the register pointer, next byte stored there, both acknowledged.
// R16: Pointer advances by one after each acknowledged write data byte.
// R17: Master writes pointer, repeated start, then address with read direction.
// R18: Read sends pointed byte; each master acknowledge advances pointer, sends next.
// R19: Master ends a read with no acknowledge then a stop.
// R20: Master ends a write with a stop after the last byte.
// R21: Slave drives data only low, released otherwise, including after stop or abort.
`default_nettype none
package pmu_serial_pkg;

  // ---------------------------------------------------------------
  // Bus constants
  // ---------------------------------------------------------------
  localparam logic [6:0] OWN_ADDR   = 7'h7E;
  localparam logic       DIR_READ   = 1'h1;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [7:0] PTR_RESET  = 8'h00;
  localparam logic [7:0] PTR_STEP   = 8'h01;

  // Protocol position of the slave
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_PTR      = 4'h3,
    ST_ACK_PTR  = 4'h4,
    ST_WDATA    = 4'h5,
    ST_ACK_W    = 4'h6,
    ST_TX       = 4'h7,
    ST_MACK     = 4'h8
  } slave_state_e;

endpackage
`default_nettype wire

//--- pin_sync.sv
// Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes the pins idle at the reset value given.
`default_nettype none
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Pins in, synchronised out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // First stage read only by the second
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule
`default_nettype wire

//--- pmu_serial_register_slave.sv
// Two-wire serial slave giving a bus master access to an 8-bit register file.
// Assumes the register file sits outside: it stores on wr_en and answers
// rd_data for reg_addr combinationally or within one clock.
`default_nettype none
`timescale 1ns/1ps
module pmu_serial_register_slave
  import pmu_serial_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe,
  // Register file side
  output var  logic [7:0] reg_addr,
  output var  logic       wr_en,
  output var  logic [7:0] wr_data,
  input  wire logic [7:0] rd_data
);

  // ---------------------------------------------------------------
  // Pin sampling and edge detection
  // ---------------------------------------------------------------
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_q;
  logic       sda_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  pin_sync #(.W(2), .INIT(2'h3)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({scl_i, sda_i}),
    .q      (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Previous synchronised levels for edge finding
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Both lines share one sync depth, so their order is preserved
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  // R5: start and stop
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  // ---------------------------------------------------------------
  // Protocol state machine
  // ---------------------------------------------------------------
  slave_state_e state;
  slave_state_e next_state;
  logic [3:0]   cnt;
  logic [3:0]   next_cnt;
  logic [7:0]   shift;
  logic [7:0]   next_shift;
  logic         rw;
  logic         next_rw;
  logic         macked;
  logic         next_macked;
  logic         next_sda_oe;
  logic [7:0]   next_reg_addr;
  logic         next_wr_en;
  logic [7:0]   next_wr_data;

  // Next-state and output decision
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_shift    = shift;
    next_rw       = rw;
    next_macked   = macked;
    next_sda_oe   = sda_oe;
    next_reg_addr = reg_addr;
    next_wr_en    = 1'h0;
    next_wr_data  = wr_data;
    if (stop_det) begin
      // R21: release on stop
      next_state  = ST_IDLE;
      next_sda_oe = 1'h0;
      next_cnt    = 4'h0;
    end else if (start_det) begin
      // R7: restart decoding; R2: partial byte dropped, never stored
      next_state  = ST_ADDR;
      next_sda_oe = 1'h0;
      next_cnt    = 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_sda_oe = 1'h0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          // R1: sample on rising edge; R4: MSB first, eight bits
          if (scl_rise && cnt != BYTE_BITS) begin
            next_shift = {shift[6:0], sda_s};
            next_cnt   = cnt + 4'h1;
          end else if (scl_fall && cnt == BYTE_BITS) begin
            next_cnt = 4'h0;
            if (state == ST_ADDR) begin
              // R12: own address only; R14: mismatch stays released
              if (shift[7:1] == OWN_ADDR) begin
                // R13: eighth bit is direction
                next_rw     = shift[0];
                next_sda_oe = 1'h1;
                next_state  = ST_ACK_ADDR;
              end else begin
                next_state = ST_IDLE;
              end
            end else if (state == ST_PTR) begin
              // R15: pointer byte latched and acknowledged
              next_reg_addr = shift;
              next_sda_oe   = 1'h1;
              next_state    = ST_ACK_PTR;
            end else begin
              // R15: data byte stored at pointer
              next_wr_en   = 1'h1;
              next_wr_data = shift;
              next_sda_oe  = 1'h1;
              next_state   = ST_ACK_W;
            end
          end
        end
        ST_ACK_ADDR: begin
          // R10: held low until the ack pulse ends
          if (scl_fall) begin
            if (rw == DIR_READ) begin
              // R18: first byte from pointed register
              next_shift  = rd_data;
              next_sda_oe = ~rd_data[7];
              next_state  = ST_TX;
            end else begin
              next_sda_oe = 1'h0;
              next_state  = ST_PTR;
            end
          end
        end
        ST_ACK_PTR: begin
          if (scl_fall) begin
            next_sda_oe = 1'h0;
            next_state  = ST_WDATA;
          end
        end
        ST_ACK_W: begin
          // R16: advance after acknowledged write byte
          if (scl_fall) begin
            next_sda_oe   = 1'h0;
            next_reg_addr = reg_addr + PTR_STEP;
            next_state    = ST_WDATA;
          end
        end
        ST_TX: begin
          // Bits change only after a falling edge
          if (scl_fall) begin
            if (cnt == LAST_BIT) begin
              // R9: release for the master's acknowledge
              next_sda_oe = 1'h0;
              next_cnt    = 4'h0;
              next_state  = ST_MACK;
            end else begin
              next_cnt    = cnt + 4'h1;
              next_shift  = {shift[6:0], 1'h0};
              next_sda_oe = ~shift[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            // R18: advance early so rd_data settles before the fall
            next_macked = ~sda_s;
            if (!sda_s) begin
              next_reg_addr = reg_addr + PTR_STEP;
            end
          end else if (scl_fall) begin
            if (macked) begin
              next_shift  = rd_data;
              next_sda_oe = ~rd_data[7];
              next_state  = ST_TX;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state  = ST_IDLE;
          next_sda_oe = 1'h0;
        end
      endcase
    end
  end

  // R21: line only ever pulled low, released from reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state    <= ST_IDLE;
      cnt      <= 4'h0;
      shift    <= 8'h00;
      rw       <= 1'h0;
      macked   <= 1'h0;
      sda_oe   <= 1'h0;
      sda_o    <= 1'h0;
      reg_addr <= PTR_RESET;
      wr_en    <= 1'h0;
      wr_data  <= 8'h00;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      shift    <= next_shift;
      rw       <= next_rw;
      macked   <= next_macked;
      sda_oe   <= next_sda_oe;
      sda_o    <= 1'h0;
      reg_addr <= next_reg_addr;
      wr_en    <= next_wr_en;
      wr_data  <= next_wr_data;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_drive_low_only: assert property (sda_o == 1'h0) // R21
    else $error("data line driven high");
  a_stop_release: assert property (stop_det |=> !sda_oe && state == ST_IDLE) // R21
    else $error("line held after stop");
  a_start_restart: assert property (start_det |=> state == ST_ADDR && cnt == 4'h0) // R7
    else $error("start did not restart address decode");
  a_edge_only: assert property ($changed(sda_oe) |-> $past(scl_fall || start_det || stop_det)) // R10
    else $error("data drive changed away from a clock fall");
  a_bit_count: assert property ((state == ST_PTR && scl_rise && cnt < BYTE_BITS && !start_det && !stop_det)
    |=> cnt == $past(cnt) + 4'h1 && shift[0] == $past(sda_s)) // R1
    else $error("received bit not counted");
  a_addr_nomatch: assert property ((state == ST_ADDR && scl_fall && cnt == BYTE_BITS && shift[7:1] != OWN_ADDR)
    |=> !sda_oe && state == ST_IDLE) // R14
    else $error("acknowledged a foreign address");
  a_write_pulse: assert property (wr_en |-> state == ST_ACK_W && sda_oe ##1 !wr_en) // R15
    else $error("write strobe malformed");
  a_write_inc: assert property ((state == ST_ACK_W && scl_fall && !start_det && !stop_det)
    |=> reg_addr == $past(reg_addr) + PTR_STEP) // R16
    else $error("pointer not advanced after write");
  a_read_inc: assert property ((state == ST_MACK && scl_rise && !sda_s && !start_det && !stop_det)
    |=> reg_addr == $past(reg_addr) + PTR_STEP) // R18
    else $error("pointer not advanced after master ack");
  a_tx_release: assert property ((state == ST_MACK) |-> !sda_oe) // R9
    else $error("line driven in master ack slot");

  c_write_byte: cover property (wr_en);
  c_read_acked: cover property (state == ST_MACK && scl_fall && macked);
  c_read_nack: cover property (state == ST_MACK && scl_fall && !macked);
  c_rep_start: cover property (start_det && state == ST_WDATA);

endmodule
`default_nettype wire

//--- bus_master.sv
// Behavioural bus master for the two-wire register slave.
// Assumes a pull-up on the data line; the slave can only pull it low.
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  // Slave pin side
  output var  logic scl,
  output wire logic sda,
  input  wire logic sda_o,
  input  wire logic sda_oe
);
  logic drv; // Master drive, 1 = released

  // ------------------------------------------------
  // Wired-AND data line
  // ------------------------------------------------
  // a released line floats high
  assign sda = drv & (sda_oe ? sda_o : 1'b1);

  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end

  // ------------------------------------------------
  // Bus conditions, 160 ns per bit
  // ------------------------------------------------
  // master makes start
  // Release first, then wait a quarter bit with clock low: the slave lets go
  // of its acknowledge some 3 clk after the fall, and rising clock before that
  // would turn its late release into a false stop
  task automatic start_cond();
    #40 drv = 1'b1;
    #40 scl = 1'b1;
    #40 drv = 1'b0;
    #40 scl = 1'b0;
  endtask

  task automatic stop_cond();
    #40 drv = 1'b0;
    #40 scl = 1'b1;
    #40 drv = 1'b1;
    #40;
  endtask

  task automatic clock_bit(input logic b, output logic seen, output logic oe);
    #40 drv = b;
    #40 scl = 1'b1;
    #40 seen = sda;
    oe = sda_oe;
    #40 scl = 1'b0;
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    logic o;
    for (int i = 7; i >= 0; i--)
      clock_bit(b[i], s, o);
    clock_bit(1'b1, s, o);
    ack = ~s;
  endtask

  // low to go on, high ends
  task automatic read_byte(input logic more, output logic [7:0] b, output logic oe_ack);
    logic s;
    logic o;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s, o);
      b[i] = s;
    end
    clock_bit(~more, s, oe_ack);
  endtask
endmodule
`default_nettype wire

//--- test_pmu_serial_register_slave.sv
// Self-checking bench for the two-wire register slave.
// Assumes a register file model here and the master model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_pmu_serial_register_slave;
  import pmu_serial_pkg::*;
  logic       clk;
  logic       resetn;
  logic       scl;
  wire        sda;
  logic       sda_o;
  logic       sda_oe;
  logic [7:0] reg_addr;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] mem [256];
  int         n_wr;
  int         num_errors;
  int         n_checks;

  pmu_serial_register_slave pmu_serial_register_slave_i (.clk(clk), .resetn(resetn),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .reg_addr(reg_addr), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data));
  bus_master bus_master_i (.scl(scl), .sda(sda), .sda_o(sda_o), .sda_oe(sda_oe));

  // ------------------------------------------------
  // Register file model
  // ------------------------------------------------
  assign rd_data = mem[reg_addr];
  always @(posedge clk) begin
    if (wr_en) begin
      mem[reg_addr] <= wr_data;
      n_wr <= n_wr + 1;
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------
  // Compares and verdict
  // ------------------------------------------------
  task automatic chk1(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  // Stop in mid data byte must store nothing
  task automatic abort_mid();
    logic a, s, o;
    int   w;
    w = n_wr;
    bus_master_i.start_cond();
    bus_master_i.write_byte({OWN_ADDR, 1'b0}, a);
    bus_master_i.write_byte(8'h20, a);
    for (int i = 0; i < 4; i++)
      bus_master_i.clock_bit(i[0], s, o);
    bus_master_i.stop_cond();
    chk1("no store", 1'b1, n_wr == w);
    chk8("reg 20 kept", 8'hDF, mem[8'h20]);
    chk1("oe after abort", 1'b0, sda_oe);
  endtask

  // Pointer, then a two byte burst
  task automatic wr_burst();
    logic a;
    bus_master_i.start_cond();
    bus_master_i.write_byte({OWN_ADDR, 1'b0}, a);
    chk1("addr ack", 1'b1, a);
    bus_master_i.write_byte(8'h10, a);
    chk1("ptr ack", 1'b1, a);
    bus_master_i.write_byte(8'hA5, a);
    chk1("data ack", 1'b1, a);
    bus_master_i.write_byte(8'h3C, a);
    chk1("burst ack", 1'b1, a);
    bus_master_i.stop_cond();
    chk8("reg 10", 8'hA5, mem[8'h10]);
    chk8("reg 11", 8'h3C, mem[8'h11]);
  endtask

  // Repeated start read, then a read from the kept pointer
  task automatic rd_burst();
    logic a, o;
    logic [7:0] d;
    bus_master_i.start_cond();
    bus_master_i.write_byte({OWN_ADDR, 1'b0}, a);
    bus_master_i.write_byte(8'h10, a);
    bus_master_i.start_cond();
    bus_master_i.write_byte({OWN_ADDR, 1'b1}, a);
    chk1("read addr ack", 1'b1, a);
    bus_master_i.read_byte(1'b1, d, o);
    chk8("read 10", 8'hA5, d);
    chk1("ack slot oe", 1'b0, o);
    bus_master_i.read_byte(1'b0, d, o);
    chk8("read 11", 8'h3C, d);
    bus_master_i.stop_cond();
    chk1("oe after stop", 1'b0, sda_oe);
    bus_master_i.start_cond();
    bus_master_i.write_byte({OWN_ADDR, 1'b1}, a);
    bus_master_i.read_byte(1'b0, d, o);
    bus_master_i.stop_cond();
    chk8("no step on nack", 8'h3C, d);
  endtask

  // Foreign addresses get no ack and no store
  task automatic bad_addr();
    logic       a;
    logic [6:0] bad [2] = '{7'h7F, 7'h3E};
    int         w;
    w = n_wr;
    for (int k = 0; k < 2; k++) begin
      bus_master_i.start_cond();
      bus_master_i.write_byte({bad[k], 1'b0}, a);
      chk1("foreign ack", 1'b0, a);
      bus_master_i.write_byte(8'h20, a);
      chk1("idle ack", 1'b0, a);
      bus_master_i.stop_cond();
    end
    chk1("no foreign store", 1'b1, n_wr == w);
  endtask

  // ------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------
  initial begin
    n_wr = 0;
    num_errors = 0;
    n_checks = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = ~i[7:0];
    resetn = 1'b0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk1("oe at reset", 1'b0, sda_oe);
    abort_mid();
    wr_burst();
    rd_burst();
    bad_addr();
    wrap_up();
  end

  // Whole run needs about 27 us
  initial begin
    #300000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
